// ### verilog/ccrs_defs.svh
`ifndef CCRS_DEFS_SVH
`define CCRS_DEFS_SVH

// =====================================================================
// Control register selectors
// =====================================================================
`define CCRS_SEL_STATUS   3'h0
`define CCRS_SEL_SAVED_SW 3'h1
`define CCRS_SEL_SAVED_RP 3'h2
`define CCRS_SEL_GLOBAL   3'h3
`define CCRS_SEL_VECTOR   3'h4

// =====================================================================
// Status word field positions
// =====================================================================
`define CCRS_SW_PRIV      30
`define CCRS_SW_BANK      29
`define CCRS_SW_BLOCK     28
`define CCRS_SW_DIV_HI    9
`define CCRS_SW_DIV_LO    8
`define CCRS_SW_IMASK_HI  7
`define CCRS_SW_IMASK_LO  4
`define CCRS_SW_SAT       1
`define CCRS_SW_CMP       0

// =====================================================================
// Masks and reset values
// =====================================================================
`define CCRS_SW_IMPL_MASK 32'h7000_03F3
`define CCRS_SW_PRIV_MASK 32'h7000_00F0
`define CCRS_SW_USER_MASK 32'h0000_0303
`define CCRS_SW_RESET     32'h7000_00F0
`define CCRS_VEC_RESET    32'h0000_0000
`define CCRS_WORD_RESET   32'h0000_0000

`endif

// ### verilog/ccrs_pkg.sv
`default_nettype none
package ccrs_pkg;

  // Access outcome of one control load or store
  typedef enum logic [1:0] {
    CCRS_ACC_IDLE,
    CCRS_ACC_OK,
    CCRS_ACC_DENIED
  } ccrs_acc_e;

  // Whole state of the register set
  typedef struct packed {
    logic [31:0] status_word;
    logic [31:0] saved_status_word;
    logic [31:0] saved_return_point;
    logic [31:0] global_base_pointer;
    logic [31:0] vector_base_pointer;
    logic [31:0] rdata;
    logic        rvalid;
    logic        denied;
    logic        bank_active;
    logic        event_mask_all;
  } ccrs_state_s;

endpackage : ccrs_pkg
`default_nettype wire

// ### verilog/ccrs_access_check.sv
`include "ccrs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Privilege decode for control register access
// =====================================================================
module ccrs_access_check (
  input  wire logic [2:0]        sel_i,
  input  wire logic              privileged_i,
  input  wire logic              req_i,
  output var  ccrs_pkg::ccrs_acc_e acc_o
);

  // Global base open to all; the other four need privilege; unused selectors are always refused
  function automatic logic sel_allowed(input logic [2:0] s,
                                       input logic       p);
    case (s)
      `CCRS_SEL_GLOBAL:   sel_allowed = 1'b1;
      `CCRS_SEL_STATUS,
      `CCRS_SEL_SAVED_SW,
      `CCRS_SEL_SAVED_RP,
      `CCRS_SEL_VECTOR:   sel_allowed = p;
      default:            sel_allowed = 1'b0;
    endcase
  endfunction : sel_allowed

  // Classify the request
  always_comb
  begin
    if (!req_i)
      acc_o = ccrs_pkg::CCRS_ACC_IDLE;
    else if (sel_allowed(sel_i, privileged_i))
      acc_o = ccrs_pkg::CCRS_ACC_OK;
    else
      acc_o = ccrs_pkg::CCRS_ACC_DENIED;
  end

endmodule : ccrs_access_check
`default_nettype wire

// ### verilog/ccrs_top.sv
`include "ccrs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Control register set of the core
// =====================================================================
module ccrs_top (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic        clk_en_i,
  // Control load / store port
  input  wire logic        ctl_load_i,
  input  wire logic        ctl_store_i,
  input  wire logic [2:0]  ctl_sel_i,
  input  wire logic [31:0] ctl_wdata_i,
  output logic      [31:0] ctl_rdata_o,
  output logic             ctl_rvalid_o,
  output logic             ctl_denied_o,
  // User-mode flag instructions
  input  wire logic        div_bits_we_i,
  input  wire logic [1:0]  div_bits_i,
  input  wire logic        sat_we_i,
  input  wire logic        sat_i,
  input  wire logic        cmp_we_i,
  input  wire logic        cmp_i,
  // Exception entry
  input  wire logic        exc_entry_i,
  input  wire logic [31:0] pc_i,
  // State seen by the core
  output logic [31:0]      status_word_o,
  output logic [31:0]      saved_status_word_o,
  output logic [31:0]      saved_return_point_o,
  output logic [31:0]      global_base_pointer_o,
  output logic [31:0]      vector_base_pointer_o,
  output logic             bank_active_o,
  output logic             event_mask_all_o
);

  ccrs_pkg::ccrs_state_s state_r;
  ccrs_pkg::ccrs_state_s state_nxt;
  ccrs_pkg::ccrs_acc_e   acc;
  logic                  priv;
  logic [31:0]           sw_wr;

  assign priv = state_r.status_word[`CCRS_SW_PRIV];

  // =====================================================================
  // Privilege check
  // =====================================================================
  ccrs_access_check u_check (
    .sel_i        (ctl_sel_i),
    .privileged_i (priv),
    .req_i        (ctl_load_i | ctl_store_i),
    .acc_o        (acc)
  );

  // Readback of a selected register
  function automatic logic [31:0] read_sel(
    input ccrs_pkg::ccrs_state_s st,
    input logic [2:0]            s);
    case (s)
      `CCRS_SEL_STATUS:   read_sel = st.status_word;
      `CCRS_SEL_SAVED_SW: read_sel = st.saved_status_word;
      `CCRS_SEL_SAVED_RP: read_sel = st.saved_return_point;
      `CCRS_SEL_GLOBAL:   read_sel = st.global_base_pointer;
      `CCRS_SEL_VECTOR:   read_sel = st.vector_base_pointer;
      default:            read_sel = `CCRS_WORD_RESET;
    endcase
  endfunction : read_sel

  // Only implemented bits survive a write; reserved stay zero
  assign sw_wr = ctl_wdata_i & `CCRS_SW_IMPL_MASK;

  // =====================================================================
  // Next state
  // =====================================================================
  always_comb
  begin
    state_nxt        = state_r;
    state_nxt.rvalid = 1'b0;
    state_nxt.denied = 1'b0;
    // Divide-step bits, allowed in any mode
    if (div_bits_we_i)
      state_nxt.status_word[`CCRS_SW_DIV_HI:`CCRS_SW_DIV_LO] =
        div_bits_i;
    // Saturation flag set/clear, any mode
    if (sat_we_i)
      state_nxt.status_word[`CCRS_SW_SAT] = sat_i;
    // Compare / carry flag, any mode
    if (cmp_we_i)
      state_nxt.status_word[`CCRS_SW_CMP] = cmp_i;
    // Control load and store
    if (acc == ccrs_pkg::CCRS_ACC_DENIED)
      state_nxt.denied = 1'b1;
    else if (acc == ccrs_pkg::CCRS_ACC_OK)
    begin
      if (ctl_store_i)
      begin
        state_nxt.rdata  = read_sel(state_r, ctl_sel_i);
        state_nxt.rvalid = 1'b1;
      end
      if (ctl_load_i)
      begin
        case (ctl_sel_i)
          `CCRS_SEL_STATUS:
            state_nxt.status_word = sw_wr;
          `CCRS_SEL_SAVED_SW:
            state_nxt.saved_status_word = ctl_wdata_i;
          `CCRS_SEL_SAVED_RP:
            state_nxt.saved_return_point = ctl_wdata_i;
          `CCRS_SEL_GLOBAL:
            state_nxt.global_base_pointer = ctl_wdata_i;
          `CCRS_SEL_VECTOR:
            state_nxt.vector_base_pointer = ctl_wdata_i;
          default:
            state_nxt.rvalid = state_nxt.rvalid;
        endcase
      end
    end
    // Exception entry wins over a same-cycle write to the saved words and to the mode bits (30:28)
    if (exc_entry_i)
    begin
      state_nxt.saved_status_word  = state_r.status_word;
      state_nxt.saved_return_point = pc_i;
      state_nxt.status_word[`CCRS_SW_PRIV]  = 1'b1;
      state_nxt.status_word[`CCRS_SW_BANK]  = 1'b1;
      state_nxt.status_word[`CCRS_SW_BLOCK] = 1'b1;
    end
    // Mirrors of derived state
    state_nxt.bank_active = state_nxt.status_word[`CCRS_SW_PRIV] &
                            state_nxt.status_word[`CCRS_SW_BANK];
    state_nxt.event_mask_all =
      state_nxt.status_word[`CCRS_SW_BLOCK];
  end

  // =====================================================================
  // State register
  // =====================================================================
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_r.status_word         <= `CCRS_SW_RESET;
      state_r.saved_status_word   <= `CCRS_WORD_RESET;
      state_r.saved_return_point  <= `CCRS_WORD_RESET;
      state_r.global_base_pointer <= `CCRS_WORD_RESET;
      state_r.vector_base_pointer <= `CCRS_VEC_RESET;
      state_r.rdata               <= `CCRS_WORD_RESET;
      state_r.rvalid              <= 1'b0;
      state_r.denied              <= 1'b0;
      state_r.bank_active         <= 1'b1;
      state_r.event_mask_all      <= 1'b1;
    end
    else if (clk_en_i)
      state_r <= state_nxt;
  end

  // =====================================================================
  // Outputs straight from flip-flops
  // =====================================================================
  assign ctl_rdata_o           = state_r.rdata;
  assign ctl_rvalid_o          = state_r.rvalid;
  assign ctl_denied_o          = state_r.denied;
  assign status_word_o         = state_r.status_word;
  assign saved_status_word_o   = state_r.saved_status_word;
  assign saved_return_point_o  = state_r.saved_return_point;
  assign global_base_pointer_o = state_r.global_base_pointer;
  assign vector_base_pointer_o = state_r.vector_base_pointer;
  assign bank_active_o         = state_r.bank_active;
  assign event_mask_all_o      = state_r.event_mask_all;

endmodule : ccrs_top
`default_nettype wire

// ### verif/ccrs_props.sv
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Port checker of the control register set
// =====================================================================
module ccrs_props (
  input wire logic        clk_sys_i,
  input wire logic        reset_n_i,
  input wire logic        clk_en_i,
  input wire logic        ctl_load_i,
  input wire logic        ctl_store_i,
  input wire logic [2:0]  ctl_sel_i,
  input wire logic [31:0] ctl_rdata_o,
  input wire logic        ctl_rvalid_o,
  input wire logic        ctl_denied_o,
  input wire logic        exc_entry_i,
  input wire logic [31:0] pc_i,
  input wire logic [31:0] status_word_o,
  input wire logic [31:0] saved_status_word_o,
  input wire logic [31:0] saved_return_point_o,
  input wire logic [31:0] global_base_pointer_o,
  input wire logic        bank_active_o,
  input wire logic        event_mask_all_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  // Exception entry effects, one cycle after the pulse
  a_exc_sets_mode: assert property (
    exc_entry_i && clk_en_i |=> status_word_o[30:28] == 3'h7)
    else $error("mode bits not set on exception");
  a_exc_save_pc: assert property (
    exc_entry_i && clk_en_i |=> saved_return_point_o == $past(pc_i))
    else $error("return point not saved");
  a_exc_save_sw: assert property (
    exc_entry_i && clk_en_i |=> saved_status_word_o == $past(status_word_o))
    else $error("status not saved");
  a_exc_keep_mask: assert property (
    exc_entry_i && clk_en_i && !ctl_load_i
    |=> $stable(status_word_o[7:4]))
    else $error("mask level changed on exception");
  // Status content and privilege decode
  a_resv_zero: assert property (
    (status_word_o & 32'h8FFF_FC0C) == 32'h0)
    else $error("reserved status bits not zero");
  a_user_denied: assert property (
    ctl_store_i && clk_en_i && !status_word_o[30] && ctl_sel_i != 3'h3
    |=> ctl_denied_o && !ctl_rvalid_o)
    else $error("user access not refused");
  a_global_user: assert property (
    ctl_store_i && clk_en_i && ctl_sel_i == 3'h3
    |=> ctl_rvalid_o && ctl_rdata_o == $past(global_base_pointer_o))
    else $error("global base read wrong");
  a_bank_user: assert property (
    bank_active_o == (status_word_o[30] && status_word_o[29]))
    else $error("bank selection wrong");
  a_block_copy: assert property (
    event_mask_all_o == status_word_o[28])
    else $error("block output differs from status");
endmodule : ccrs_props
`default_nettype wire

// ### verif/ccrs_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Exception source of the core
// =====================================================================
module ccrs_core_model (
  input  wire logic        clk_sys_i,
  output var  logic        exc_entry_o,
  output var  logic [31:0] pc_o
);
  // Quiet until the first exception
  initial
  begin
    exc_entry_o = 1'b0;
    pc_o        = 32'h0;
  end

  // One-cycle entry pulse carrying the counter value
  task automatic raise(input logic [31:0] pc);
    @(posedge clk_sys_i);
    exc_entry_o <= 1'b1;
    pc_o        <= pc;
    @(posedge clk_sys_i);
    exc_entry_o <= 1'b0;
    pc_o        <= ~pc; // Stale counter is not shown
    #1;
  endtask : raise
endmodule : ccrs_core_model
`default_nettype wire

// ### verif/tb_cpu_control_register_set.sv
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Testbench of the control register set
// =====================================================================
module tb_cpu_control_register_set;
  logic clk_sys_i = 0, reset_n_i = 0, clk_en_i = 1, ctl_load_i = 0;
  logic ctl_store_i = 0, div_bits_we_i = 0, sat_we_i = 0, cmp_we_i = 0;
  logic sat_i = 0, cmp_i = 0, ctl_rvalid_o, ctl_denied_o;
  logic bank_active_o, event_mask_all_o;
  logic [1:0]  div_bits_i = 0;
  logic [2:0]  ctl_sel_i = 0;
  logic [31:0] ctl_wdata_i = 0, ctl_rdata_o, status_word_o, sw_saved;
  logic [31:0] rp_saved, gb_o, vb_o;
  wire  logic        exc_entry_i;
  wire  logic [31:0] pc_i;
  int n_mismatch = 0, n_checks = 0, cycles = 0;

  ccrs_top DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i), .ctl_load_i(ctl_load_i), .ctl_store_i(ctl_store_i),
    .ctl_sel_i(ctl_sel_i), .ctl_wdata_i(ctl_wdata_i),
    .ctl_rdata_o(ctl_rdata_o), .ctl_rvalid_o(ctl_rvalid_o),
    .ctl_denied_o(ctl_denied_o), .div_bits_we_i(div_bits_we_i),
    .div_bits_i(div_bits_i), .sat_we_i(sat_we_i), .sat_i(sat_i),
    .cmp_we_i(cmp_we_i), .cmp_i(cmp_i), .exc_entry_i(exc_entry_i),
    .pc_i(pc_i), .status_word_o(status_word_o),
    .saved_status_word_o(sw_saved), .saved_return_point_o(rp_saved),
    .global_base_pointer_o(gb_o), .vector_base_pointer_o(vb_o),
    .bank_active_o(bank_active_o), .event_mask_all_o(event_mask_all_o));
  ccrs_core_model core (.clk_sys_i(clk_sys_i), .exc_entry_o(exc_entry_i),
    .pc_o(pc_i));

  // Clock and hang guard
  always #2 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  // Comparisons
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask : chk1

  // One control load (ld=1) or store, with refusal and read data
  task automatic acc(input logic ld, input logic [2:0] sel,
                     input logic [31:0] wd, input logic dn,
                     input logic [31:0] rd);
    @(posedge clk_sys_i);
    ctl_load_i  <= ld;
    ctl_store_i <= !ld;
    ctl_sel_i   <= sel;
    ctl_wdata_i <= wd;
    @(posedge clk_sys_i);
    ctl_load_i  <= 1'b0;
    ctl_store_i <= 1'b0;
    #1;
    chk1(ctl_denied_o, dn);
    chk1(ctl_rvalid_o, !ld && !dn);
    if (!ld && !dn) chk32(ctl_rdata_o, rd);
  endtask : acc

  // Verdict
  task automatic final_report();
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    acc(0, 3'h0, 0, 0, 32'h7000_00F0);
    acc(0, 3'h4, 0, 0, 32'h0);
    for (int i = 1; i < 5; i++)
    begin
      acc(1, i[2:0], 32'hA5A5_0000 | 32'(i), 0, 0);
      acc(0, i[2:0], 0, 0, 32'hA5A5_0000 | 32'(i));
    end
    chk32(gb_o, 32'hA5A5_0003);
    chk32(vb_o, 32'hA5A5_0004);
    for (int i = 5; i < 8; i++) acc(0, i[2:0], 0, 1, 0);
    acc(1, 3'h0, 32'hFFFF_FFFF, 0, 0);
    acc(0, 3'h0, 0, 0, 32'h7000_03F3);
    acc(1, 3'h0, 32'h2000_0050, 0, 0);
    chk1(bank_active_o, 1'b0);
    for (int i = 0; i < 5; i++)
      if (i != 3) acc(0, i[2:0], 0, 1, 0);
    acc(1, 3'h0, 32'h7000_00F0, 1, 0);
    acc(1, 3'h3, 32'h1234_0003, 0, 0);
    acc(0, 3'h3, 0, 0, 32'h1234_0003);
    @(posedge clk_sys_i);
    {div_bits_we_i, sat_we_i, cmp_we_i} <= 3'h7;
    {div_bits_i, sat_i, cmp_i} <= 4'hF;
    @(posedge clk_sys_i);
    {div_bits_we_i, sat_we_i, cmp_we_i} <= 3'h0;
    #1;
    chk32(status_word_o, 32'h2000_0353);
    core.raise(32'hCAFE_0010);
    chk32(status_word_o, 32'h7000_0353);
    chk32(sw_saved, 32'h2000_0353);
    chk32(rp_saved, 32'hCAFE_0010);
    chk1(bank_active_o, 1'b1);
    chk1(event_mask_all_o, 1'b1);
    acc(0, 3'h2, 0, 0, 32'hCAFE_0010);
    // Clock enable low freezes state: a load must not land
    @(posedge clk_sys_i);
    clk_en_i <= 1'b0;
    acc(1, 3'h3, 32'h0BAD_0000, 0, 0);
    @(posedge clk_sys_i);
    clk_en_i <= 1'b1;
    #1;
    chk32(gb_o, 32'h1234_0003);
    final_report();
  end
endmodule : tb_cpu_control_register_set

bind ccrs_top ccrs_props u_props (.clk_sys_i(clk_sys_i),
  .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .ctl_load_i(ctl_load_i),
  .ctl_store_i(ctl_store_i), .ctl_sel_i(ctl_sel_i),
  .ctl_rdata_o(ctl_rdata_o), .ctl_rvalid_o(ctl_rvalid_o),
  .ctl_denied_o(ctl_denied_o), .exc_entry_i(exc_entry_i), .pc_i(pc_i),
  .status_word_o(status_word_o), .saved_status_word_o(saved_status_word_o),
  .saved_return_point_o(saved_return_point_o),
  .global_base_pointer_o(global_base_pointer_o),
  .bank_active_o(bank_active_o), .event_mask_all_o(event_mask_all_o));
`default_nettype wire
